// >>> flash_prot_pkg.sv
package flash_prot_pkg;

  localparam logic [15:0] ADDR_RANGE_END_HIGH = 16'hffa6;
  localparam logic [15:0] ADDR_RANGE_END_LOW = 16'hffa7;
  localparam logic [15:0] ADDR_WRITE_BUFFER = 16'hffa8;
  localparam logic [15:0] ADDR_PROTECT_BYTE = 16'h0081;

  localparam logic [7:0] RESET_BYTE = 8'h00;
  localparam logic [7:0] ERASED_BYTE = 8'hff;
  localparam logic [3:0] HIGH_NIBBLE_ZERO = 4'h0;

  // protect byte layout
  localparam int PROT_SEL_LSB = 2;
  localparam int PROT_SEL_MSB = 6;
  localparam logic [7:0] PROT_FIXED_MASK = 8'h83;

  // number of flash blocks per device size
  localparam int BLOCKS_MAX = 16;
  localparam logic [1:0] SIZE_4BLK = 2'h0;
  localparam logic [1:0] SIZE_8BLK = 2'h1;
  localparam logic [1:0] SIZE_16BLK = 2'h2;

  localparam logic [4:0] SEL_NONE = 5'h1f;

  // flash command codes
  localparam logic [2:0] CMD_VERIFY = 3'h1;
  localparam logic [2:0] CMD_ERASE = 3'h3;
  localparam logic [2:0] CMD_BLANK = 3'h4;
  localparam logic [2:0] CMD_WRITE = 3'h5;

  typedef enum logic [1:0] {
    SEQ_IDLE,
    SEQ_WALK,
    SEQ_DONE
  } seq_state_t;

endpackage

// >>> flash_range_protect_monitor.sv
`timescale 1ns/100ps
module flash_range_protect_monitor (
  input wire logic clk_sys,
  input wire logic sys_rst,
  input wire logic [15:0] cpuAddr,
  input wire logic cpuWrite,
  input wire logic cpuRead,
  input wire logic cpuBitOp,
  input wire logic [7:0] cpuRdata,
  input wire logic cpuHit,
  input wire logic [7:0] protectByte,
  input wire logic selfProgMode,
  input wire logic cmdStart,
  input wire logic seqBusy,
  input wire logic seqStep,
  input wire logic [15:0] seqAddr,
  input wire logic seqDone,
  input wire logic flashWriteEn,
  input wire logic flashEraseEn,
  input wire logic [7:0] flashWdata,
  input wire logic write_erase_protect_error
);
  default clocking mcb @(posedge clk_sys); endclocking
  default disable iff (sys_rst);
  reset_clears_a: assert property ($past(sys_rst) && !sys_rst |->
    cpuRdata == 8'h00 && flashWdata == 8'h00 && !seqBusy) else $error("reset left state");
  hit_decode_a: assert property (cpuHit == (cpuAddr >= 16'hffa6 && cpuAddr <= 16'hffa8))
    else $error("bad register hit");
  unmapped_read_a: assert property (cpuRead && !cpuHit |=> cpuRdata == 8'h00)
    else $error("unmapped read not zero");
  buffer_bitop_a: assert property (cpuWrite && cpuBitOp && cpuAddr == 16'hffa8 |=>
    $stable(flashWdata)) else $error("bit write changed buffer");
  walk_step_a: assert property (seqStep |=>
    (seqStep && seqAddr == $past(seqAddr) + 16'h0001) or (!seqStep && seqBusy ##1 seqDone))
    else $error("pointer did not step");
  mode_gate_a: assert property (cmdStart && !seqBusy && !selfProgMode |=>
    seqStep && !write_erase_protect_error) else $error("protection outside mode");
  bad_code_a: assert property (cmdStart && !seqBusy && selfProgMode &&
    protectByte == 8'h83 |=> write_erase_protect_error && !seqStep) else $error("code not safe");
  blocked_flash_a: assert property (write_erase_protect_error |->
    !flashWriteEn && !flashEraseEn && !seqBusy) else $error("blocked command ran");
endmodule // flash_range_protect_monitor
bind flash_self_program_range_protect flash_range_protect_monitor mon (.clk_sys, .sys_rst,
  .cpuAddr, .cpuWrite, .cpuRead, .cpuBitOp, .cpuRdata, .cpuHit, .protectByte, .selfProgMode,
  .cmdStart, .seqBusy, .seqStep, .seqAddr, .seqDone, .flashWriteEn, .flashEraseEn,
  .flashWdata, .write_erase_protect_error);

// >>> flash_self_program_range_protect.sv
`timescale 1ns/100ps
// Functional notes
// - The sequencer walks the start pointer up until it equals the high and low compare values.
// - Reset clears both compare registers and the write buffer to zero.
// - Compare registers take bit and byte writes and read back what was written.
// - The write buffer holds the byte that the next byte write programs.
// - Protection applies only in self-programming mode and never in other modes.
// - A self-programming write or erase to a protected block leaves the flash unchanged.
// - The protect byte holds a five-bit selection in bits 6 to 2 with bits 7, 1, 0 at one.
// - Four-block device: 01110 shields 0-3, 01111 shields 0-1, 11111 shields none.
// - Eight-block device: 01100 to 01111 shield 0-7, 0-5, 0-3, 0-1; 11111 shields none.
// - Sixteen-block device: 01000 to 01111 shield 0-15 down to 0-1 in steps of two.
// - A command aimed at a shielded block raises the protect error flag.
module flash_self_program_range_protect (
  input wire logic clk_sys,
  input wire logic sys_rst,
  input wire logic [1:0] deviceSize,
  input wire logic [15:0] cpuAddr,
  input wire logic cpuWrite,
  input wire logic cpuRead,
  input wire logic cpuBitOp,
  input wire logic [2:0] cpuBitSel,
  input wire logic [7:0] cpuWdata,
  output logic [7:0] cpuRdata,
  output logic cpuHit,
  input wire logic [7:0] protectByte,
  input wire logic selfProgMode,
  input wire logic cmdStart,
  input wire logic [2:0] cmdCode,
  input wire logic [7:0] start_pointer_high,
  input wire logic [7:0] start_pointer_low,
  output logic seqBusy,
  output logic seqStep,
  output logic [15:0] seqAddr,
  output logic seqDone,
  output logic flashWriteEn,
  output logic flashEraseEn,
  output logic [7:0] flashWdata,
  output logic write_erase_protect_error
);
  typedef struct packed {
    logic [7:0] rangeEndHigh;
    logic [7:0] rangeEndLow;
    logic [7:0] writeBuffer;
    logic [7:0] rdata;
    logic [2:0] cmd;
    logic blocked;
    logic protErr;
  } regs_t;

  regs_t cur_r, cur_nxt;
  logic [15:0] protMask;
  logic walkBusy;
  logic walkStep;
  logic walkDone;
  logic [15:0] walkAddr;
  logic targetProt;
  logic launch;
  logic selHigh;
  logic selLow;
  logic selBuf;

  protect_decode u_decode (
    .protectByte(protectByte),
    .deviceSize(deviceSize),
    .protMask(protMask)
  );

  // the high start pointer carries the block number; upper nibble is kept zero by software
  assign targetProt = protMask[start_pointer_high[3:0]] && selfProgMode;
  assign launch = cmdStart && !walkBusy;

  range_walker u_walk (
    .clk_sys(clk_sys),
    .sys_rst(sys_rst),
    .start(launch && !targetProt),
    .startHigh(start_pointer_high),
    .startLow(start_pointer_low),
    .endHigh(cur_r.rangeEndHigh),
    .endLow(cur_r.rangeEndLow),
    .busy(walkBusy),
    .stepValid(walkStep),
    .curAddr(walkAddr),
    .done(walkDone)
  );

  assign selHigh = (cpuAddr == flash_prot_pkg::ADDR_RANGE_END_HIGH);
  assign selLow = (cpuAddr == flash_prot_pkg::ADDR_RANGE_END_LOW);
  assign selBuf = (cpuAddr == flash_prot_pkg::ADDR_WRITE_BUFFER);

  function automatic logic [7:0] bitMerge(input logic [7:0] old, input logic [2:0] idx,
                                          input logic val);
    logic [7:0] tmp;
    tmp = old;
    tmp[idx] = val;
    return tmp;
  endfunction

  always_comb begin
    cur_nxt = cur_r;
    if (cpuWrite && selHigh) begin
      // single-bit writes take bit 0 of the data as the new value
      cur_nxt.rangeEndHigh = cpuBitOp ? bitMerge(cur_r.rangeEndHigh, cpuBitSel, cpuWdata[0])
                                      : cpuWdata;
    end
    if (cpuWrite && selLow) begin
      cur_nxt.rangeEndLow = cpuBitOp ? bitMerge(cur_r.rangeEndLow, cpuBitSel, cpuWdata[0])
                                     : cpuWdata;
    end
    // a bit operation would be a read-modify-write racing the sequencer, so it is dropped
    if (cpuWrite && selBuf && !cpuBitOp) begin
      cur_nxt.writeBuffer = cpuWdata;
    end
    cur_nxt.rdata = flash_prot_pkg::RESET_BYTE;
    if (cpuRead) begin
      if (selHigh) cur_nxt.rdata = cur_r.rangeEndHigh;
      else if (selLow) cur_nxt.rdata = cur_r.rangeEndLow;
      else if (selBuf) cur_nxt.rdata = cur_r.writeBuffer;
    end
    if (launch) begin
      cur_nxt.cmd = cmdCode;
      cur_nxt.blocked = targetProt;
    end else if (walkDone) begin
      cur_nxt.blocked = 1'b0;
    end
    // one-cycle pulse per blocked launch; the status register owner makes it sticky
    cur_nxt.protErr = launch && targetProt;
  end

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      cur_r <= '0;
    end else begin
      cur_r <= cur_nxt;
    end
  end

  assign cpuRdata = cur_r.rdata;
  assign cpuHit = selHigh || selLow || selBuf;
  assign seqBusy = walkBusy;
  assign seqStep = walkStep;
  assign seqAddr = walkAddr;
  assign seqDone = walkDone;
  // flash strobes are never raised for a shielded block, so its data survives
  assign flashWriteEn = walkStep && !cur_r.blocked
                        && (cur_r.cmd == flash_prot_pkg::CMD_WRITE);
  assign flashEraseEn = walkStep && !cur_r.blocked
                        && (cur_r.cmd == flash_prot_pkg::CMD_ERASE);
  assign flashWdata = cur_r.writeBuffer;
  assign write_erase_protect_error = cur_r.protErr;
endmodule // flash_self_program_range_protect

// >>> flash_self_program_range_protect_tb.sv
`timescale 1ns/100ps
module flash_self_program_range_protect_tb;
  logic clk_sys = 1'h0;
  logic sys_rst = 1'h1;
  logic [1:0] deviceSize = 2'h0;
  logic [15:0] cpuAddr = 16'h0000;
  logic cpuWrite = 1'h0, cpuRead = 1'h0, cpuBitOp = 1'h0, selfProgMode = 1'h1, cmdStart = 1'h0;
  logic [2:0] cpuBitSel = 3'h0, cmdCode = 3'h1;
  logic [7:0] cpuWdata = 8'h00, protectByte = 8'hff;
  logic [7:0] start_pointer_high = 8'h00, start_pointer_low = 8'h00, cpuRdata, flashWdata;
  logic [15:0] seqAddr;
  logic cpuHit, seqBusy, seqStep, seqDone, flashWriteEn, flashEraseEn, write_erase_protect_error;
  int nErrors = 0, samplesChecked = 0;
  always #12.5 clk_sys = ~clk_sys;
  flash_self_program_range_protect dut (.clk_sys, .sys_rst, .deviceSize, .cpuAddr, .cpuWrite,
    .cpuRead, .cpuBitOp, .cpuBitSel, .cpuWdata, .cpuRdata, .cpuHit, .protectByte, .selfProgMode,
    .cmdStart, .cmdCode, .start_pointer_high, .start_pointer_low, .seqBusy, .seqStep, .seqAddr,
    .seqDone, .flashWriteEn, .flashEraseEn, .flashWdata, .write_erase_protect_error);
  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    samplesChecked++;
    if (seen !== exp) begin
      nErrors++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic giveVerdict;
    $display("comparisons %0d mismatches %0d", samplesChecked, nErrors);
    if (nErrors == 0 && samplesChecked > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  // bit writes take their value from data bit 0
  task automatic acc(input logic [15:0] a, input logic w, input logic bo, input logic [2:0] b,
      input logic [7:0] d);
    @(posedge clk_sys);
    #1;
    cpuAddr = a;
    cpuWrite = w;
    cpuRead = !w;
    cpuBitOp = bo;
    cpuBitSel = b;
    cpuWdata = d;
    @(posedge clk_sys);
    #1;
    cpuWrite = 1'h0;
    cpuRead = 1'h0;
  endtask
  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    acc(a, 1'h1, 1'h0, 3'h0, d);
  endtask
  task automatic rd(input logic [15:0] a, input logic [7:0] e);
    acc(a, 1'h0, 1'h0, 3'h0, 8'h00);
    check("read data", {8'h00, cpuRdata}, {8'h00, e});
  endtask
  task automatic run(input logic [2:0] c, input logic [7:0] hi, input logic [7:0] lo,
      input logic [7:0] endLo, input logic err);
    int n;
    int s;
    n = 0;
    s = 0;
    wr(16'hffa6, hi);
    wr(16'hffa7, endLo);
    @(posedge clk_sys);
    #1;
    cmdCode = c;
    start_pointer_high = hi;
    start_pointer_low = lo;
    cmdStart = 1'h1;
    @(posedge clk_sys);
    #1;
    cmdStart = 1'h0;
    check("protect error", {15'h0000, write_erase_protect_error}, {15'h0000, err});
    if (!err) begin
      check("walk start", seqStep ? seqAddr : 16'h0000, {hi, lo});
      while (!seqDone && n < 600) begin
        n++;
        s += int'(flashWriteEn | flashEraseEn);
        @(posedge clk_sys);
        #1;
      end
      // the done pulse trails the walker's closing state by a cycle, which the loop also counts
      check("walk length", 16'(n), 16'(endLo - lo) + 16'h0002);
      check("strobes", 16'(s), (c == flash_prot_pkg::CMD_WRITE || c == flash_prot_pkg::CMD_ERASE)
        ? 16'(endLo - lo) + 16'h0001 : 16'h0000);
    end
  endtask
  // the highest shielded block must refuse, the next one up must walk
  task automatic tryProt(input logic [4:0] code, input int top);
    protectByte = {1'h1, code, 2'h3};
    if (top >= 0) run(flash_prot_pkg::CMD_ERASE, top[7:0], 8'h00, 8'h00, 1'h1);
    if (top + 1 < (4 << deviceSize)) run(flash_prot_pkg::CMD_ERASE, 8'(top + 1), 8'h00, 8'h00, 1'h0);
  endtask
  initial begin
    #1000000;
    nErrors++;
    $display("watchdog expired");
    giveVerdict();
  end
  initial begin
    repeat (4) @(posedge clk_sys);
    #1;
    sys_rst = 1'h0;
    rd(16'hffa6, 8'h00);
    rd(16'hffa7, 8'h00);
    rd(16'hffa8, 8'h00);
    $display("reset values done");
    wr(16'hffa6, 8'h05);
    wr(16'hffa7, 8'ha5);
    wr(16'hffa8, 8'h3c);
    acc(16'hffa7, 1'h1, 1'h1, 3'h6, 8'h01);
    acc(16'hffa6, 1'h1, 1'h1, 3'h0, 8'h00);
    acc(16'hffa8, 1'h1, 1'h1, 3'h0, 8'h01);
    rd(16'hffa6, 8'h04);
    rd(16'hffa7, 8'he5);
    rd(16'hffa8, 8'h3c);
    rd(16'hffa9, 8'h00);
    check("buffer out", {8'h00, flashWdata}, 16'h003c);
    $display("register access done");
    run(flash_prot_pkg::CMD_VERIFY, 8'h02, 8'h0c, 8'h10, 1'h0);
    run(flash_prot_pkg::CMD_ERASE, 8'h01, 8'h00, 8'h00, 1'h0);
    run(flash_prot_pkg::CMD_BLANK, 8'h03, 8'hf0, 8'hff, 1'h0);
    run(flash_prot_pkg::CMD_WRITE, 8'h00, 8'h40, 8'h40, 1'h0);
    $display("range walk done");
    for (int s = 0; s < 3; s++) begin
      deviceSize = s[1:0];
      for (int k = 0; k < (2 << s); k++) begin
        tryProt(5'(16 - (2 << s) + k), (4 << s) - 1 - 2 * k);
      end
      tryProt(5'h1f, -1);
      tryProt(5'h00, (4 << s) - 1);
    end
    $display("protect decode done");
    selfProgMode = 1'h0;
    run(flash_prot_pkg::CMD_ERASE, 8'h00, 8'h00, 8'h00, 1'h0);
    selfProgMode = 1'h1;
    @(posedge clk_sys);
    #1;
    sys_rst = 1'h1;
    @(posedge clk_sys);
    #1;
    sys_rst = 1'h0;
    rd(16'hffa6, 8'h00);
    rd(16'hffa7, 8'h00);
    rd(16'hffa8, 8'h00);
    $display("mode and reset done");
    giveVerdict();
  end
endmodule // flash_self_program_range_protect_tb

// >>> protect_decode.sv
`timescale 1ns/100ps
// turns the five-bit selection into a mask of protected blocks
module protect_decode (
  input wire logic [7:0] protectByte,
  input wire logic [1:0] deviceSize,
  output logic [15:0] protMask
);
  logic [4:0] sel;
  logic [4:0] topBlock;
  logic noneProt;
  logic badSel;

  always_comb begin
    sel = protectByte[flash_prot_pkg::PROT_SEL_MSB:flash_prot_pkg::PROT_SEL_LSB];
    noneProt = (sel == flash_prot_pkg::SEL_NONE);
    badSel = 1'b0;
    topBlock = 5'h0f;
    unique case (deviceSize)
      flash_prot_pkg::SIZE_4BLK: begin
        // 01110 -> 0..3, 01111 -> 0..1
        if (sel == 5'h0e) topBlock = 5'h03;
        else if (sel == 5'h0f) topBlock = 5'h01;
        else badSel = 1'b1;
      end
      flash_prot_pkg::SIZE_8BLK: begin
        if (sel >= 5'h0c && sel <= 5'h0f) begin
          topBlock = 5'(7 - 2 * (32'(sel) - 12));
        end else begin
          badSel = 1'b1;
        end
      end
      default: begin
        if (sel >= 5'h08 && sel <= 5'h0f) begin
          topBlock = 5'(15 - 2 * (32'(sel) - 8));
        end else begin
          badSel = 1'b1;
        end
      end
    endcase
    // all ones is the listed shield-nothing code for every size, not an unlisted one
    if (noneProt) badSel = 1'b0;
    // fixed bits must read as one, otherwise the byte is corrupt
    if ((protectByte & flash_prot_pkg::PROT_FIXED_MASK) != flash_prot_pkg::PROT_FIXED_MASK) begin
      badSel = 1'b1;
    end
    // unlisted codes fail safe by shielding everything
    if (badSel && !noneProt) topBlock = 5'h0f;
  end

  genvar b;
  for (b = 0; b < flash_prot_pkg::BLOCKS_MAX; b++) begin : g_mask
    assign protMask[b] = (!noneProt || badSel) && (5'(b) <= topBlock);
  end
endmodule // protect_decode

// >>> range_walker.sv
`timescale 1ns/100ps
// steps a pointer pair until it meets the compare pair
module range_walker (
  input wire logic clk_sys,
  input wire logic sys_rst,
  input wire logic start,
  input wire logic [7:0] startHigh,
  input wire logic [7:0] startLow,
  input wire logic [7:0] endHigh,
  input wire logic [7:0] endLow,
  output logic busy,
  output logic stepValid,
  output logic [15:0] curAddr,
  output logic done
);
  typedef struct packed {
    flash_prot_pkg::seq_state_t st;
    logic [7:0] ptrHigh;
    logic [7:0] ptrLow;
    logic done;
  } walk_t;

  walk_t cur_r, cur_nxt;

  always_comb begin
    cur_nxt = cur_r;
    cur_nxt.done = 1'b0;
    unique case (cur_r.st)
      flash_prot_pkg::SEQ_IDLE: begin
        if (start) begin
          cur_nxt.ptrHigh = startHigh;
          cur_nxt.ptrLow = startLow;
          cur_nxt.st = flash_prot_pkg::SEQ_WALK;
        end
      end
      flash_prot_pkg::SEQ_WALK: begin
        // stop when both halves match the compare values
        if (cur_r.ptrHigh == endHigh && cur_r.ptrLow == endLow) begin
          cur_nxt.st = flash_prot_pkg::SEQ_DONE;
        end else begin
          {cur_nxt.ptrHigh, cur_nxt.ptrLow} = {cur_r.ptrHigh, cur_r.ptrLow} + 16'h0001;
        end
      end
      flash_prot_pkg::SEQ_DONE: begin
        cur_nxt.done = 1'b1;
        cur_nxt.st = flash_prot_pkg::SEQ_IDLE;
      end
      default: cur_nxt.st = flash_prot_pkg::SEQ_IDLE;
    endcase
  end

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      cur_r <= '0;
    end else begin
      cur_r <= cur_nxt;
    end
  end

  assign busy = (cur_r.st != flash_prot_pkg::SEQ_IDLE);
  assign stepValid = (cur_r.st == flash_prot_pkg::SEQ_WALK);
  assign curAddr = {cur_r.ptrHigh, cur_r.ptrLow};
  assign done = cur_r.done;
endmodule // range_walker
